/* include/sst_pkg.sv */
/*
  Shared constants, carriers and helpers of the synchronous serial transmitter.
  Assumes a single 20 MHz system clock and an AXI4-Lite register port.
*/
`default_nettype none
package sst_pkg;

  // ==========================================================
  // register map (byte addresses)
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_FILL = 8'h08;
  localparam logic [7:0] REG_INT_STAT = 8'h0c;
  localparam logic [7:0] REG_INT_MASK = 8'h10;

  // ==========================================================
  // reset values and field positions
  localparam logic [7:0] FILL_RST = 8'hff;
  localparam logic [3:0] CTRL_RST = 4'hc;
  localparam logic [1:0] MASK_RST = 2'h0;
  localparam int IRQ_EMPTY = 0;
  localparam int IRQ_FILL = 1;
  localparam logic [3:0] MIN_DATA_BITS = 4'h5;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam int SYNC_W = 11;
  // strobe pin idles high, everything else low
  localparam logic [10:0] PINS_RST = 11'h004;

  // ==========================================================
  // types
  typedef struct packed {
    logic [1:0] len;
    logic parity_inhibit;
    logic parity_even_select;
  } sst_cfg_t;

  typedef struct packed {
    logic [7:0] data;
    logic strobe_n;
    logic cts;
    logic bclk;
  } sst_pins_t;

  typedef enum logic {ST_IDLE, ST_SHIFT} sst_state_t;
  typedef enum logic [1:0] {NX_HOLD, NX_FILL, NX_STOP} sst_next_t;

  // ==========================================================
  // helpers
  // data bits masked to the length, parity placed just above them
  function automatic logic [8:0] sst_frame(input logic [7:0] d, input sst_cfg_t c);
    logic [7:0] m;
    logic p;
    logic [3:0] n;
    n = MIN_DATA_BITS + {2'h0, c.len};
    m = d & ~(8'hff << n);
    p = (^m) ^ ~c.parity_even_select;
    sst_frame = {1'b0, m} | ({8'h00, p & ~c.parity_inhibit} << n);
  endfunction : sst_frame

  function automatic logic [3:0] sst_total(input sst_cfg_t c);
    sst_total = MIN_DATA_BITS + {2'h0, c.len} + {3'h0, ~c.parity_inhibit};
  endfunction : sst_total

  function automatic logic sst_addr_ok(input logic [7:0] a);
    sst_addr_ok = (a == REG_CTRL) || (a == REG_STATUS) || (a == REG_FILL) ||
                  (a == REG_INT_STAT) || (a == REG_INT_MASK);
  endfunction : sst_addr_ok

endpackage : sst_pkg
`default_nettype wire

/* hw/sst_sync.sv */
/*
  Two-stage synchroniser for a bundle of pin levels.
  Assumes the inputs are slow levels; multi-bit words are only sampled
  while the sender holds them steady.
*/
`timescale 1ns/10ps
`default_nettype none
module sst_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST = '0
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // levels
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] meta;

  // first stage feeds only the second
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      meta <= RST;
      q <= RST;
    end else begin
      meta <= d;
      q <= meta;
    end
  end

endmodule : sst_sync
`default_nettype wire

/* hw/sst_transmitter.sv */
/*
  Synchronous-mode serial transmitter: holding register, fill character,
  parity, clear-to-send gating, flags, AXI4-Lite registers and interrupt.
  Assumes pins come from outside the clock domain and the transmit bit
  clock is far slower than sys_clk (at least 8 sys_clk cycles per half bit).
*/
`timescale 1ns/10ps
`default_nettype none
// Behaviour
// - A loaded character gets odd, even or no parity as configured.
// - The next character source is chosen at the middle of the last bit.
// - With no held character the fill goes next and the fill flag rises.
// - A new held character clears the fill flag and follows the fill with no gap.
// - The empty flag is high while the holding register can take a character.
// - The holding register follows the data pins while the load strobe is low.
// - With clear-to-send low or a character in flight the held character waits.
// - Clear-to-send high at a bit boundary while idle, or a character ending, moves the held character and sets empty.
// - A loaded character is shifted out as a plain NRZ stream.
// - Clear-to-send low at the middle of the last bit ends transmission after that character, line at mark.
// - The delimiter is low on the last bit of a character and while idle.
// - The length field picks five to eight data bits.
// - Shorter characters use only the low bits of data and fill.
// - Reset goes idle: line mark, empty high, delimiter low, fill all ones.
module sst_transmitter
  import sst_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // parallel side pins
  input wire logic [7:0] char_data_inputs,
  input wire logic holding_load_strobe_n,
  input wire logic clear_to_send,
  input wire logic tx_bit_clk,
  // serial side and flags
  output logic serial_line_out,
  output logic last_bit_delimiter,
  output logic holding_empty_flag,
  output logic fill_substituted_flag,
  output logic irq,
  // axi4-lite write
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  // ==========================================================
  // pin synchronisation
  sst_pins_t pins_raw;
  sst_pins_t pins_s;
  logic bclk_d;
  logic bclk_rise;
  logic bclk_fall;

  assign pins_raw = {char_data_inputs, holding_load_strobe_n, clear_to_send, tx_bit_clk};

  sst_sync #(
    .W(SYNC_W),
    .RST(PINS_RST)
  ) u_sync (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .d(pins_raw),
    .q(pins_s)
  );

  // bit clock edge detection on the synchronised level
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      bclk_d <= 1'b0;
    end else begin
      bclk_d <= pins_s.bclk;
    end
  end

  assign bclk_rise = pins_s.bclk & ~bclk_d;
  assign bclk_fall = ~pins_s.bclk & bclk_d;

  // ==========================================================
  // state
  sst_cfg_t cfg;
  logic [7:0] fill_reg;
  logic [7:0] hold_data;
  sst_state_t state;
  sst_next_t next_sel;
  logic [8:0] shreg;
  logic [3:0] bit_cnt;
  logic [3:0] cur_total;
  logic last_bit;
  logic ld_go;
  logic ld_hold;
  logic [8:0] ld_frame;
  logic [1:0] int_stat;
  logic [1:0] int_mask;
  logic [1:0] int_clr;
  logic [1:0] int_ev;
  logic wr_en;
  logic rd_en;

  assign last_bit = (bit_cnt == cur_total - 4'h1);

  // ==========================================================
  // load decision at a bit boundary
  always_comb begin
    ld_hold = 1'b0;
    ld_go = 1'b0;
    if (bclk_rise) begin
      case (state)
        ST_IDLE: begin
          ld_hold = pins_s.cts & ~holding_empty_flag;
          ld_go = ld_hold;
        end
        ST_SHIFT: begin
          if (last_bit) begin
            ld_hold = (next_sel == NX_HOLD);
            ld_go = (next_sel != NX_STOP);
          end
        end
        default: ld_go = 1'b0;
      endcase
    end
    // masking and parity happen on the way in
    ld_frame = sst_frame(ld_hold ? hold_data : fill_reg, cfg);
  end

  // ==========================================================
  // holding register, a latch sampled on sys_clk
  // capture beats the transfer so a character loaded in the same cycle is kept
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      hold_data <= 8'h00;
      holding_empty_flag <= 1'b1;
    end else if (!pins_s.strobe_n) begin
      hold_data <= pins_s.data;
      holding_empty_flag <= 1'b0;
    end else if (ld_hold) begin
      holding_empty_flag <= 1'b1;
    end
  end

  // ==========================================================
  // source choice at the middle of the last bit
  // clear-to-send is judged here, so a late drop still lets one more go
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      next_sel <= NX_STOP;
    end else if (bclk_fall && state == ST_SHIFT && last_bit) begin
      if (!pins_s.cts) begin
        next_sel <= NX_STOP;
      end else if (!holding_empty_flag) begin
        next_sel <= NX_HOLD;
      end else begin
        next_sel <= NX_FILL;
      end
    end
  end

  // ==========================================================
  // shift engine, line and delimiter
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= ST_IDLE;
      shreg <= 9'h000;
      bit_cnt <= 4'h0;
      cur_total <= 4'h0;
      serial_line_out <= 1'b1;
      last_bit_delimiter <= 1'b0;
    end else if (ld_go) begin
      state <= ST_SHIFT;
      serial_line_out <= ld_frame[0];
      shreg <= ld_frame >> 1;
      bit_cnt <= 4'h0;
      cur_total <= sst_total(cfg);
      last_bit_delimiter <= 1'b1;
    end else if (bclk_rise) begin
      case (state)
        ST_SHIFT: begin
          if (last_bit) begin
            state <= ST_IDLE;
            serial_line_out <= 1'b1;
            last_bit_delimiter <= 1'b0;
          end else begin
            serial_line_out <= shreg[0];
            shreg <= shreg >> 1;
            bit_cnt <= bit_cnt + 4'h1;
            last_bit_delimiter <= (bit_cnt + 4'h2 != cur_total);
          end
        end
        default: begin
          serial_line_out <= 1'b1;
          last_bit_delimiter <= 1'b0;
        end
      endcase
    end
  end

  // ==========================================================
  // fill-substituted flag: the hardware set wins over a load
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      fill_substituted_flag <= 1'b0;
    end else if (ld_go && !ld_hold) begin
      fill_substituted_flag <= 1'b1;
    end else if (!pins_s.strobe_n) begin
      fill_substituted_flag <= 1'b0;
    end
  end

  // ==========================================================
  // axi4-lite write channel: address and data taken together
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else begin
      s_axi_awready <= s_axi_awvalid & s_axi_wvalid & ~s_axi_awready & ~s_axi_bvalid;
      s_axi_wready <= s_axi_awvalid & s_axi_wvalid & ~s_axi_awready & ~s_axi_bvalid;
      if (wr_en) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= sst_addr_ok(s_axi_awaddr) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  assign wr_en = s_axi_awready & s_axi_awvalid;
  assign int_clr = (wr_en && s_axi_wstrb[0] && s_axi_awaddr == REG_INT_STAT) ?
                   s_axi_wdata[1:0] : 2'h0;

  // software-written configuration, fill character and interrupt mask
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg <= CTRL_RST;
      fill_reg <= FILL_RST;
      int_mask <= MASK_RST;
    end else if (wr_en && s_axi_wstrb[0]) begin
      case (s_axi_awaddr)
        REG_CTRL: cfg <= s_axi_wdata[3:0];
        REG_FILL: fill_reg <= s_axi_wdata[7:0];
        REG_INT_MASK: int_mask <= s_axi_wdata[1:0];
        default: int_mask <= int_mask;
      endcase
    end
  end

  // ==========================================================
  // axi4-lite read channel
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= RESP_OKAY;
    end else begin
      s_axi_arready <= s_axi_arvalid & ~s_axi_arready & ~s_axi_rvalid;
      if (rd_en) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= sst_addr_ok(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
        case (s_axi_araddr)
          REG_CTRL: s_axi_rdata <= {28'h0, cfg};
          REG_STATUS: s_axi_rdata <= {27'h0, pins_s.cts, state == ST_SHIFT,
                                      last_bit_delimiter, fill_substituted_flag,
                                      holding_empty_flag};
          REG_FILL: s_axi_rdata <= {24'h0, fill_reg};
          REG_INT_STAT: s_axi_rdata <= {30'h0, int_stat};
          REG_INT_MASK: s_axi_rdata <= {30'h0, int_mask};
          default: s_axi_rdata <= 32'h0000_0000;
        endcase
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  assign rd_en = s_axi_arready & s_axi_arvalid;

  // ==========================================================
  // interrupt: sticky events, write one to clear, set wins
  assign int_ev[IRQ_EMPTY] = ld_hold;
  assign int_ev[IRQ_FILL] = ld_go & ~ld_hold;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      int_stat <= 2'h0;
      irq <= 1'b0;
    end else begin
      int_stat <= (int_stat & ~int_clr) | int_ev;
      irq <= |(int_stat & int_mask);
    end
  end

  // ==========================================================
  // checks
  logic fill_written;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      fill_written <= 1'b0;
    end else if (wr_en && s_axi_awaddr == REG_FILL) begin
      fill_written <= 1'b1;
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  a_parity_value:
    assert property (ld_go && !cfg.parity_inhibit |-> (^ld_frame) == ~cfg.parity_even_select)
    else $error("parity bit wrong on load");

  a_short_masked:
    assert property (ld_go |-> (ld_frame >> sst_total(cfg)) == 9'h000)
    else $error("bits above the character length not zero");

  a_fill_on_empty:
    assert property (bclk_rise && state == ST_SHIFT && last_bit && next_sel == NX_FILL
                     |=> fill_substituted_flag && state == ST_SHIFT)
    else $error("fill not sent with flag high");

  a_hold_waits_busy:
    assert property (state == ST_SHIFT && !bclk_rise && !holding_empty_flag
                     |=> !holding_empty_flag)
    else $error("held character left mid character");

  a_cts_low_idle:
    assert property (state == ST_IDLE && !pins_s.cts |=> state == ST_IDLE && serial_line_out)
    else $error("left idle without clear-to-send");

  a_idle_delim_mark:
    assert property (state == ST_IDLE |-> serial_line_out && !last_bit_delimiter)
    else $error("idle line not at mark or delimiter high");

  a_lsb_first_out:
    assert property (ld_go |=> serial_line_out == $past(ld_frame[0]) ##0 bit_cnt == 4'h0)
    else $error("first bit is not the least significant one");

  a_empty_on_move:
    assert property (ld_hold && pins_s.strobe_n |=> holding_empty_flag && state == ST_SHIFT)
    else $error("empty flag not set by transfer");

  a_fill_reset_ones:
    assert property (!fill_written |-> fill_reg == FILL_RST)
    else $error("fill register not all ones after reset");

  a_load_clears_fill:
    assert property (!pins_s.strobe_n && !ld_go |=> !fill_substituted_flag && !holding_empty_flag)
    else $error("load did not clear fill and empty flags");
endmodule : sst_transmitter
`default_nettype wire

/* test/sst_line_model.sv */
/*
  Line-side model: makes the transmit bit clock and clear-to-send, and
  records the line and delimiter levels at the middle of every bit.
  Assumes the bench steers clear-to-send through cts_req.
*/
`timescale 1ns/10ps
`default_nettype none
module sst_line_model #(
  parameter int HALF = 10
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // bench control
  input wire logic cts_req,
  // line side
  input wire logic serial_line_out,
  input wire logic last_bit_delimiter,
  output logic clear_to_send,
  output logic tx_bit_clk
);
  // ==========================================================
  // bit clock and capture
  logic [1:0] rx_q[$];
  int cnt;

  // free-running bit clock: a sync line keeps clocking between characters
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt <= 0;
      tx_bit_clk <= 1'b0;
      clear_to_send <= 1'b0;
    end else begin
      clear_to_send <= cts_req;
      cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
      if (cnt == HALF - 1) begin
        tx_bit_clk <= ~tx_bit_clk;
        // sample at mid bit, far from the pin delays
        if (tx_bit_clk) begin
          rx_q.push_back({last_bit_delimiter, serial_line_out});
        end
      end
    end
  end
endmodule : sst_line_model
`default_nettype wire

/* test/sync_serial_transmitter_test.sv */
/*
  Self-checking bench of the serial transmitter: registers, frames, fill, interrupt.
  Assumes sst_line_model on the line side and a 20 MHz sys_clk.
*/
`timescale 1ns/10ps
`default_nettype none
module sync_serial_transmitter_test
  import sst_pkg::*;
;
  // ==========================================================
  // signals
  logic sys_clk, rst_n, cts_req, holding_load_strobe_n, clear_to_send, tx_bit_clk;
  logic serial_line_out, last_bit_delimiter, holding_empty_flag, fill_substituted_flag, irq;
  logic [7:0] char_data_inputs, s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp;
  logic [3:0] s_axi_wstrb;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [1:0] exp_q[$];
  int fail_count = 0;
  int checks_done = 0;
  int cycles = 0;

  sst_transmitter sst_transmitter_inst (
    .sys_clk(sys_clk), .rst_n(rst_n), .char_data_inputs(char_data_inputs),
    .holding_load_strobe_n(holding_load_strobe_n), .clear_to_send(clear_to_send),
    .tx_bit_clk(tx_bit_clk), .serial_line_out(serial_line_out),
    .last_bit_delimiter(last_bit_delimiter), .holding_empty_flag(holding_empty_flag),
    .fill_substituted_flag(fill_substituted_flag), .irq(irq),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready)
  );

  sst_line_model #(.HALF(10)) sst_line_model_inst (
    .sys_clk(sys_clk), .rst_n(rst_n), .cts_req(cts_req), .serial_line_out(serial_line_out),
    .last_bit_delimiter(last_bit_delimiter), .clear_to_send(clear_to_send),
    .tx_bit_clk(tx_bit_clk)
  );

  // ==========================================================
  // clock and watchdog
  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end

  // a hang counts as a mismatch and closes the run
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      fail_count++;
      complete_run();
    end
  end

  // ==========================================================
  // tasks
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    checks_done++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask : check

  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : complete_run

  // each channel released at its own handshake
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d);
    logic aw_open, w_open;
    aw_open = 1'b1;
    w_open = 1'b1;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (aw_open || w_open) begin
      @(posedge sys_clk);
      if (aw_open && s_axi_awready === 1'b1) begin
        aw_open = 1'b0;
        s_axi_awvalid <= 1'b0;
      end
      if (w_open && s_axi_wready === 1'b1) begin
        w_open = 1'b0;
        s_axi_wvalid <= 1'b0;
      end
    end
    while (s_axi_bvalid !== 1'b1) @(posedge sys_clk);
    resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
    @(posedge sys_clk); // idle edge so no signal is driven twice at once
  endtask : axi_write

  task automatic axi_read(input logic [7:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge sys_clk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    while (s_axi_rvalid !== 1'b1) @(posedge sys_clk);
    rd = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
    @(posedge sys_clk); // idle edge so no signal is driven twice at once
  endtask : axi_read

  // junk first, then the real character; latches must end on the last value
  task automatic load_char(input logic [7:0] d);
    char_data_inputs <= 8'($urandom);
    holding_load_strobe_n <= 1'b0;
    repeat (4) @(posedge sys_clk);
    char_data_inputs <= d;
    repeat (5) @(posedge sys_clk);
    holding_load_strobe_n <= 1'b1;
    repeat (5) @(posedge sys_clk); // data held past strobe rise
    char_data_inputs <= 8'($urandom);
  endtask : load_char

  // sel 0 waits for empty, sel 1 for the fill flag
  task automatic wait_until(input int sel, input int lim);
    for (int i = 0; i < lim; i++) begin
      if (((sel == 0) ? holding_empty_flag : fill_substituted_flag) === 1'b1) break;
      @(posedge sys_clk);
    end
  endtask : wait_until

  // expected {delimiter, line} per bit: lsb first, parity last
  task automatic add_frame(input logic [7:0] d, input logic [3:0] c);
    int nd, n;
    logic p;
    nd = 5 + int'(c[3:2]);
    n = nd + 1 - int'(c[1]);
    p = ~c[0];
    for (int k = 0; k < nd; k++) begin
      p = p ^ d[k];
    end
    for (int k = 0; k < n; k++) begin
      exp_q.push_back({k != n - 1, (k < nd) ? d[k] : p});
    end
  endtask : add_frame

  task automatic compare_stream();
    logic [1:0] rx[$];
    int s;
    rx = sst_line_model_inst.rx_q;
    s = 0;
    while (s < rx.size() && rx[s][1] !== 1'b1) s++;
    foreach (exp_q[k]) begin
      check(32'(rx[s + k][0]), 32'(exp_q[k][0]), "line bit");
      check(32'(rx[s + k][1]), 32'(exp_q[k][1]), "delimiter");
    end
    check(32'(rx[s + exp_q.size()]), 32'h1, "mark after");
    check(32'(rx[rx.size() - 1]), 32'h1, "still idle");
  endtask : compare_stream

  // one character, or character, fill and a late second character
  task automatic run_chars(input logic [7:0] a, input logic [7:0] b, input logic [7:0] f,
                           input logic [3:0] c, input logic two);
    exp_q.delete();
    add_frame(a, c);
    if (two) begin
      add_frame(f, c);
      add_frame(b, c);
    end
    sst_line_model_inst.rx_q.delete();
    load_char(a);
    repeat (40) @(posedge sys_clk);
    check(32'(holding_empty_flag), 32'h0, "held while cts low");
    cts_req <= 1'b1;
    wait_until(0, 100);
    check(32'(holding_empty_flag), 32'h1, "moved on cts");
    if (two) begin
      wait_until(1, 400);
      check(32'(fill_substituted_flag), 32'h1, "fill substituted");
      load_char(b);
      check(32'(fill_substituted_flag), 32'h0, "fill flag cleared");
      check(32'(holding_empty_flag), 32'h0, "held behind fill");
      wait_until(0, 400);
    end
    cts_req <= 1'b0;
    repeat (500) @(posedge sys_clk);
    compare_stream();
  endtask : run_chars

  // ==========================================================
  // main sequence
  initial begin
    logic [3:0] c;
    logic [7:0] d;
    rst_n = 1'b0;
    cts_req = 1'b0;
    holding_load_strobe_n = 1'b1;
    char_data_inputs = 8'h00;
    s_axi_awaddr = 8'h00;
    s_axi_araddr = 8'h00;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hf;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    d = 8'($urandom(50));
    repeat (20) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    check(32'(serial_line_out), 32'h1, "line at mark");
    check(32'(last_bit_delimiter), 32'h0, "delimiter idle");
    check(32'(holding_empty_flag), 32'h1, "empty after reset");
    check(32'(irq), 32'h0, "irq after reset");
    axi_read(REG_CTRL);
    check(rd, 32'(CTRL_RST), "ctrl reset");
    axi_read(REG_FILL);
    check(rd, 32'hff, "fill reset");
    // a write with the low byte lane off must leave the fill alone
    s_axi_wstrb <= 4'he;
    axi_write(REG_FILL, 32'h0);
    s_axi_wstrb <= 4'hf;
    axi_read(REG_FILL);
    check(rd, 32'hff, "fill kept on lane off");
    axi_read(REG_STATUS);
    check(rd, 32'h1, "status reset");
    axi_read(8'h14);
    check(32'(resp), 32'(RESP_SLVERR), "unmapped read");
    axi_write(8'h18, 32'h0);
    check(32'(resp), 32'(RESP_SLVERR), "unmapped write");
    // every length with odd, even and no parity; corners at both ends
    for (int i = 0; i < 12; i++) begin
      c[3:2] = 2'(i / 3);
      c[1] = (i % 3 == 2);
      c[0] = (i % 3 == 1) || (c[1] && $urandom_range(1) == 1);
      d = (i == 0) ? 8'h00 : (i == 11) ? 8'hff : 8'($urandom);
      axi_write(REG_CTRL, 32'(c));
      run_chars(d, 8'h00, 8'h00, c, 1'b0);
    end
    // masked event, then unmask, then clear
    check(32'(irq), 32'h0, "masked irq");
    axi_read(REG_INT_STAT);
    check(rd, 32'h1, "move event");
    axi_write(REG_INT_MASK, 32'h3);
    repeat (3) @(posedge sys_clk);
    check(32'(irq), 32'h1, "irq raised");
    axi_write(REG_INT_STAT, 32'h1);
    repeat (3) @(posedge sys_clk);
    check(32'(irq), 32'h0, "irq cleared");
    // fill: first the reset fill of all ones, then a short one with high bits set
    for (int j = 0; j < 2; j++) begin
      c = (j == 0) ? CTRL_RST : 4'h5;
      d = (j == 0) ? 8'hff : (8'($urandom) | 8'hc0);
      axi_write(REG_CTRL, 32'(c));
      if (j == 1) begin
        axi_write(REG_FILL, 32'(d));
      end
      run_chars(8'($urandom), 8'($urandom), d, c, 1'b1);
      check(32'(irq), 32'h1, "irq on events");
      axi_read(REG_INT_STAT);
      check(rd, 32'h3, "both events");
      axi_write(REG_INT_STAT, 32'h3);
    end
    axi_read(REG_INT_STAT);
    check(rd, 32'h0, "events cleared");
    complete_run();
  end
endmodule : sync_serial_transmitter_test
`default_nettype wire
